// ===== shared/bridge_cfg_pkg.sv
// constants shared by the interrupt pin, porch quiet window and lane registers
// assumes one 50 MHz clock and a word-addressed 16-bit register port
package bridge_cfg_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] IRQ_MASK_ADDR = 8'hc5;
    localparam logic [7:0] IRQ_STAT_ADDR = 8'hc6;
    localparam logic [7:0] IRQ_PIN_ADDR  = 8'hdc;
    localparam logic [7:0] PORCH_ADDR    = 8'hdd;
    localparam logic [7:0] LANE_ADDR     = 8'hde;

    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    localparam int IRQ_POL_BIT   = 0;
    localparam int IRQ_TYPE_LSB  = 1;
    localparam int IRQ_TYPE_W    = 2;
    localparam int BP_QUIET_LSB  = 4;
    localparam int FP_QUIET_LSB  = 0;
    localparam int QUIET_W       = 4;
    localparam int LANE_LSB      = 0;
    localparam int LANE_W        = 2;
    localparam int NUM_LANES     = 4;
    localparam int PORCH_LEN_W   = 8;
    localparam int REG_W         = 16;

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic [2:0] IRQ_PIN_RST = 3'h0;
    localparam logic [7:0] PORCH_RST   = 8'h00;
    localparam logic [1:0] LANE_RST    = 2'h0;

    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    localparam logic [1:0] IRQ_PUSH_PULL = 2'h0;
    localparam logic [1:0] IRQ_OD_LOW    = 2'h1;
    localparam logic       IF_SEL_RGB_SPI = 1'b0;

    // interrupt event bits
    localparam int EV_QUIET   = 0;
    localparam int EV_BLOCKED = 1;
    localparam int EV_REFUSED = 2;
    localparam int NUM_EV     = 3;
    localparam logic [NUM_EV-1:0] EV_RST = 3'h0;

endpackage

// ===== hdl/irq_pin_driver.sv
// interrupt pin driver: push-pull or open-drain, either polarity
// assumes irq_req_i is a synchronous level; oe_n low means the pin is driven
module irq_pin_driver
    import bridge_cfg_pkg::*;
(
    input  wire logic       sys_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [1:0] irq_output_type_i,
    input  wire logic       irq_active_level_i,
    input  wire logic       irq_req_i,
    output logic            irq_o,
    output logic            irq_oe_n_o
);

    logic pin_r,  pin_nxt;
    logic oe_n_r, oe_n_nxt;

    always_comb begin
        if (irq_output_type_i[1]) begin
            // wired-or: only ever pulls high
            pin_nxt  = 1'b1;
            oe_n_nxt = ~irq_req_i;                     // RQ1
        end else if (irq_output_type_i == IRQ_OD_LOW) begin
            // wired-and: only ever pulls low
            pin_nxt  = 1'b0;
            oe_n_nxt = ~irq_req_i;                     // RQ1
        end else begin
            pin_nxt  = irq_active_level_i ? irq_req_i : ~irq_req_i; // RQ4
            oe_n_nxt = 1'b0;                           // RQ1
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_r  <= 1'b1;
            oe_n_r <= 1'b0;
        end else begin
            pin_r  <= pin_nxt;
            oe_n_r <= oe_n_nxt;
        end
    end

    assign irq_o      = pin_r;
    assign irq_oe_n_o = oe_n_r;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_pp_level;
        (irq_output_type_i == IRQ_PUSH_PULL) |=>
            (!irq_oe_n_o && irq_o == ($past(irq_req_i) == $past(irq_active_level_i)));
    endproperty
    a_pp_level: assert property (p_pp_level) else $error("push-pull level wrong"); // RQ4

    property p_od_low;
        (irq_output_type_i == IRQ_OD_LOW) |=> (!irq_o && irq_oe_n_o == !$past(irq_req_i));
    endproperty
    a_od_low: assert property (p_od_low) else $error("open-drain low drive wrong"); // RQ1

endmodule

// ===== hdl/porch_quiet_gate.sv
// porch quiet window: holds back non-video packets near the active area
// assumes the video timing block gives porch position as synchronous levels
module porch_quiet_gate
    import bridge_cfg_pkg::*;
(
    input  wire logic             sys_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             window_gating_enable_i,
    input  wire logic             host_if_sel_i,
    input  wire logic [QUIET_W-1:0] back_porch_quiet_lines_i,
    input  wire logic [QUIET_W-1:0] front_porch_quiet_lines_i,
    input  wire logic [7:0]       vert_back_porch_len_i,
    input  wire logic [7:0]       vert_front_porch_len_i,
    input  wire logic             in_back_porch_i,
    input  wire logic [7:0]       bp_lines_left_i,
    input  wire logic             in_front_porch_i,
    input  wire logic [7:0]       fp_line_idx_i,
    input  wire logic             burst_mode_i,
    input  wire logic             nonvideo_burst_option_i,
    output logic                  nonvideo_hold_o,
    output logic                  nonvideo_blocked_o
);

    logic       active;
    logic [7:0] bp_req, fp_req, eff_bp, eff_fp;
    logic       hold_r, hold_nxt, blk_r, blk_nxt;

    always_comb begin
        active = window_gating_enable_i && (host_if_sel_i == IF_SEL_RGB_SPI); // RQ9
        bp_req = {4'h0, back_porch_quiet_lines_i};
        fp_req = {4'h0, front_porch_quiet_lines_i};
        eff_bp = (bp_req > vert_back_porch_len_i) ? vert_back_porch_len_i : bp_req;  // RQ6
        eff_fp = (fp_req > vert_front_porch_len_i) ? vert_front_porch_len_i : fp_req; // RQ8
        // bp_lines_left counts 1 on the line just before the first active line
        hold_nxt = active &&
                   ((in_back_porch_i && bp_lines_left_i != 8'h00 &&
                     bp_lines_left_i <= eff_bp) ||              // RQ5
                    (in_front_porch_i && fp_line_idx_i < eff_fp)); // RQ7
        blk_nxt = active && (bp_req >= vert_back_porch_len_i) &&
                  (fp_req >= vert_front_porch_len_i) &&
                  (!burst_mode_i || nonvideo_burst_option_i); // RQ10
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hold_r <= 1'b0;
            blk_r  <= 1'b0;
        end else begin
            hold_r <= hold_nxt;
            blk_r  <= blk_nxt;
        end
    end

    assign nonvideo_hold_o    = hold_r;
    assign nonvideo_blocked_o = blk_r;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_gate_off;
        !(window_gating_enable_i && host_if_sel_i == IF_SEL_RGB_SPI) |=>
            !nonvideo_hold_o && !nonvideo_blocked_o;
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("quiet window active while gated off"); // RQ9

    property p_fp_window;
        (window_gating_enable_i && host_if_sel_i == IF_SEL_RGB_SPI && in_front_porch_i &&
         fp_line_idx_i < {4'h0, front_porch_quiet_lines_i} &&
         fp_line_idx_i < vert_front_porch_len_i) |=> nonvideo_hold_o;
    endproperty
    a_fp_window: assert property (p_fp_window) else $error("front porch line not held"); // RQ7

    property p_bp_cap;
        (in_back_porch_i && !in_front_porch_i &&
         bp_lines_left_i > vert_back_porch_len_i) |=> !nonvideo_hold_o;
    endproperty
    a_bp_cap: assert property (p_bp_cap) else $error("back porch window not capped"); // RQ6

    property p_bp_window;
        (window_gating_enable_i && host_if_sel_i == IF_SEL_RGB_SPI && in_back_porch_i &&
         bp_lines_left_i != 8'h00 && bp_lines_left_i <= {4'h0, back_porch_quiet_lines_i} &&
         bp_lines_left_i <= vert_back_porch_len_i) |=> nonvideo_hold_o;
    endproperty
    a_bp_window: assert property (p_bp_window) else $error("back porch line not held"); // RQ5

endmodule

// ===== hdl/bridge_irq_lane_window_regs.sv
// register slice: interrupt pin setup, porch quiet window, data lane count,
// plus the interrupt mask and sticky status that feed the pin
// assumes a plain strobe register port, one 50 MHz clock, async active-low reset
//
// Strobed register access was left to the implementer.

// ------------------------------------------------------------
// Operation
// (RQ1) the two-bit output type picks push-pull, open-drain low wired-and, or open-drain high wired-or.
// (RQ2) software sets polarity 0 with open-drain low and 1 with open-drain high.
// (RQ3) writes to output type and polarity are dropped unless every interrupt enable bit is zero.
// (RQ4) polarity 0 makes the pin idle high and assert low, polarity 1 idle low and assert high.
// (RQ5) no non-video packet goes out in the last N back porch lines before the first active line.
// (RQ6) a back porch quiet count above the back porch length is treated as that length.
// (RQ7) no non-video packet goes out in the first M front porch lines after the last active line.
// (RQ8) a front porch quiet count above the front porch length is treated as that length.
// (RQ9) both quiet windows act only with gating enabled and the parallel plus serial host port.
// (RQ10) when both counts cover their porches, non-video traffic stops in non-burst or burst with the option set.
// (RQ11) the lane count field selects one, two, three or four active data lanes.
// (RQ12) reserved bits read as zero and ignore writes.
// ------------------------------------------------------------
module bridge_irq_lane_window_regs
    import bridge_cfg_pkg::*;
(
    input  wire logic                 sys_clk_i,
    input  wire logic                 rst_n_i,
    // register port
    input  wire logic [7:0]           reg_addr_i,
    input  wire logic [REG_W-1:0]     reg_wdata_i,
    input  wire logic                 reg_wr_i,
    input  wire logic                 reg_rd_i,
    output logic      [REG_W-1:0]     reg_rdata_o,
    // video timing and mode
    input  wire logic                 window_gating_enable_i,
    input  wire logic                 host_if_sel_i,
    input  wire logic [PORCH_LEN_W-1:0] vert_back_porch_len_i,
    input  wire logic [PORCH_LEN_W-1:0] vert_front_porch_len_i,
    input  wire logic                 in_back_porch_i,
    input  wire logic [7:0]           bp_lines_left_i,
    input  wire logic                 in_front_porch_i,
    input  wire logic [7:0]           fp_line_idx_i,
    input  wire logic                 burst_mode_i,
    input  wire logic                 nonvideo_burst_option_i,
    // to the link side
    output logic                      nonvideo_hold_o,
    output logic                      nonvideo_blocked_o,
    output logic      [LANE_W-1:0]    lane_count_sel_o,
    output logic      [NUM_LANES-1:0] lane_enable_o,
    // interrupt pin: oe_n low while driven
    output logic                      irq_o,
    output logic                      irq_oe_n_o
);

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [IRQ_TYPE_W-1:0] irq_output_type_r, irq_output_type_nxt;
    logic                  irq_active_level_r, irq_active_level_nxt;
    logic [QUIET_W-1:0]    back_porch_quiet_lines_r, back_porch_quiet_lines_nxt;
    logic [QUIET_W-1:0]    front_porch_quiet_lines_r, front_porch_quiet_lines_nxt;
    logic [LANE_W-1:0]     lane_count_sel_r, lane_count_sel_nxt;
    logic [NUM_EV-1:0]     irq_mask_r, irq_mask_nxt;
    logic [NUM_EV-1:0]     irq_stat_r, irq_stat_nxt;
    logic [REG_W-1:0]      rdata_r, rdata_nxt;
    logic [NUM_LANES-1:0]  lane_en_r, lane_en_nxt;
    logic                  irq_req_r, irq_req_nxt;
    logic                  hold_d_r, blk_d_r;

    logic                  wr_pin, wr_porch, wr_lane, wr_mask, wr_stat;
    logic                  cfg_locked;
    logic [NUM_EV-1:0]     events;
    logic [NUM_EV-1:0]     stat_clr;
    logic                  hold_w, blk_w;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    always_comb begin
        wr_pin   = reg_wr_i && (reg_addr_i == IRQ_PIN_ADDR);
        wr_porch = reg_wr_i && (reg_addr_i == PORCH_ADDR);
        wr_lane  = reg_wr_i && (reg_addr_i == LANE_ADDR);
        wr_mask  = reg_wr_i && (reg_addr_i == IRQ_MASK_ADDR);
        wr_stat  = reg_wr_i && (reg_addr_i == IRQ_STAT_ADDR);
        // the pin setup must not change while any interrupt enable bit is set
        cfg_locked = (irq_mask_r != EV_RST);
    end

    // ------------------------------------------------------------
    // configuration fields
    // ------------------------------------------------------------
    always_comb begin
        irq_output_type_nxt         = irq_output_type_r;
        irq_active_level_nxt        = irq_active_level_r;
        back_porch_quiet_lines_nxt  = back_porch_quiet_lines_r;
        front_porch_quiet_lines_nxt = front_porch_quiet_lines_r;
        lane_count_sel_nxt          = lane_count_sel_r;
        irq_mask_nxt                = irq_mask_r;
        if (wr_pin && !cfg_locked) begin                                      // RQ3
            irq_output_type_nxt  = reg_wdata_i[IRQ_TYPE_LSB +: IRQ_TYPE_W];  // RQ1
            irq_active_level_nxt = reg_wdata_i[IRQ_POL_BIT];                  // RQ4
        end
        if (wr_porch) begin
            back_porch_quiet_lines_nxt  = reg_wdata_i[BP_QUIET_LSB +: QUIET_W];
            front_porch_quiet_lines_nxt = reg_wdata_i[FP_QUIET_LSB +: QUIET_W];
        end
        if (wr_lane) begin
            lane_count_sel_nxt = reg_wdata_i[LANE_LSB +: LANE_W];             // RQ11
        end
        if (wr_mask) begin
            irq_mask_nxt = reg_wdata_i[NUM_EV-1:0];
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_output_type_r         <= IRQ_PIN_RST[IRQ_TYPE_LSB +: IRQ_TYPE_W];
            irq_active_level_r        <= IRQ_PIN_RST[IRQ_POL_BIT];
            back_porch_quiet_lines_r  <= PORCH_RST[BP_QUIET_LSB +: QUIET_W];
            front_porch_quiet_lines_r <= PORCH_RST[FP_QUIET_LSB +: QUIET_W];
            lane_count_sel_r          <= LANE_RST;
            irq_mask_r                <= EV_RST;
        end else begin
            irq_output_type_r         <= irq_output_type_nxt;
            irq_active_level_r        <= irq_active_level_nxt;
            back_porch_quiet_lines_r  <= back_porch_quiet_lines_nxt;
            front_porch_quiet_lines_r <= front_porch_quiet_lines_nxt;
            lane_count_sel_r          <= lane_count_sel_nxt;
            irq_mask_r                <= irq_mask_nxt;
        end
    end

    // ------------------------------------------------------------
    // lane enables, one per data lane
    // ------------------------------------------------------------
    for (genvar g = 0; g < NUM_LANES; g++) begin : g_lane
        assign lane_en_nxt[g] = (lane_count_sel_r >= LANE_W'(g));            // RQ11
    end

    // ------------------------------------------------------------
    // interrupt events and sticky status
    // ------------------------------------------------------------
    always_comb begin
        events             = '0;
        events[EV_QUIET]   = hold_w && !hold_d_r;
        events[EV_BLOCKED] = blk_w && !blk_d_r;
        events[EV_REFUSED] = wr_pin && cfg_locked;
        stat_clr           = wr_stat ? reg_wdata_i[NUM_EV-1:0] : EV_RST;
        // an event in the clearing cycle survives the clear
        irq_stat_nxt       = (irq_stat_r & ~stat_clr) | events;
        irq_req_nxt        = |(irq_stat_nxt & irq_mask_nxt);
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_stat_r <= EV_RST;
            irq_req_r  <= 1'b0;
            hold_d_r   <= 1'b0;
            blk_d_r    <= 1'b0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            irq_req_r  <= irq_req_nxt;
            hold_d_r   <= hold_w;
            blk_d_r    <= blk_w;
        end
    end

    // ------------------------------------------------------------
    // read data: valid only in the cycle after the read strobe
    // ------------------------------------------------------------
    always_comb begin
        rdata_nxt = '0;
        if (reg_rd_i) begin
            case (reg_addr_i)
                IRQ_PIN_ADDR: begin
                    rdata_nxt[IRQ_TYPE_LSB +: IRQ_TYPE_W] = irq_output_type_r;
                    rdata_nxt[IRQ_POL_BIT]                = irq_active_level_r;
                end
                PORCH_ADDR: begin
                    rdata_nxt[BP_QUIET_LSB +: QUIET_W] = back_porch_quiet_lines_r;
                    rdata_nxt[FP_QUIET_LSB +: QUIET_W] = front_porch_quiet_lines_r;
                end
                LANE_ADDR:     rdata_nxt[LANE_LSB +: LANE_W] = lane_count_sel_r;
                IRQ_MASK_ADDR: rdata_nxt[NUM_EV-1:0] = irq_mask_r;
                IRQ_STAT_ADDR: rdata_nxt[NUM_EV-1:0] = irq_stat_r;
                default:       rdata_nxt = '0;                                // RQ12
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_r   <= '0;
            lane_en_r <= '0;
        end else begin
            rdata_r   <= rdata_nxt;
            lane_en_r <= lane_en_nxt;
        end
    end

    assign reg_rdata_o      = rdata_r;
    assign lane_count_sel_o = lane_count_sel_r;
    assign lane_enable_o    = lane_en_r;

    // ------------------------------------------------------------
    // sub-blocks
    // ------------------------------------------------------------
    porch_quiet_gate u_gate (
        .sys_clk_i                 (sys_clk_i),
        .rst_n_i                   (rst_n_i),
        .window_gating_enable_i    (window_gating_enable_i),
        .host_if_sel_i             (host_if_sel_i),
        .back_porch_quiet_lines_i  (back_porch_quiet_lines_r),
        .front_porch_quiet_lines_i (front_porch_quiet_lines_r),
        .vert_back_porch_len_i     (vert_back_porch_len_i),
        .vert_front_porch_len_i    (vert_front_porch_len_i),
        .in_back_porch_i           (in_back_porch_i),
        .bp_lines_left_i           (bp_lines_left_i),
        .in_front_porch_i          (in_front_porch_i),
        .fp_line_idx_i             (fp_line_idx_i),
        .burst_mode_i              (burst_mode_i),
        .nonvideo_burst_option_i   (nonvideo_burst_option_i),
        .nonvideo_hold_o           (hold_w),
        .nonvideo_blocked_o        (blk_w)
    );

    assign nonvideo_hold_o    = hold_w;
    assign nonvideo_blocked_o = blk_w;

    // the polarity is not checked against the type; a mismatch is software's to avoid
    irq_pin_driver u_pin (
        .sys_clk_i          (sys_clk_i),
        .rst_n_i            (rst_n_i),
        .irq_output_type_i  (irq_output_type_r),
        .irq_active_level_i (irq_active_level_r),
        .irq_req_i          (irq_req_r),
        .irq_o              (irq_o),
        .irq_oe_n_o         (irq_oe_n_o)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_locked_pin_wr;
        reg_wr_i && reg_addr_i == IRQ_PIN_ADDR && irq_mask_r != EV_RST;
    endsequence

    sequence s_open_pin_wr;
        reg_wr_i && reg_addr_i == IRQ_PIN_ADDR && irq_mask_r == EV_RST;
    endsequence

    property p_cfg_lock;
        s_locked_pin_wr |=> $stable(irq_output_type_r) && $stable(irq_active_level_r)
                            && irq_stat_r[EV_REFUSED];
    endproperty
    a_cfg_lock: assert property (p_cfg_lock) else $error("locked pin setup changed"); // RQ3

    property p_cfg_take;
        s_open_pin_wr ##1 reg_rd_i && reg_addr_i == IRQ_PIN_ADDR |=>
            reg_rdata_o == ($past(reg_wdata_i, 2) & 16'h0007);
    endproperty
    a_cfg_take: assert property (p_cfg_take) else $error("pin setup write lost"); // RQ1

    property p_porch_reserved;
        reg_rd_i && reg_addr_i == PORCH_ADDR |=> reg_rdata_o[15:8] == 8'h00;
    endproperty
    a_porch_reserved: assert property (p_porch_reserved) else $error("reserved bits set"); // RQ12

    property p_lane_map;
        wr_lane ##1 !wr_lane |=> lane_enable_o ==
            (4'hf >> (2'h3 - $past(reg_wdata_i[1:0], 2)));
    endproperty
    a_lane_map: assert property (p_lane_map) else $error("lane enables wrong"); // RQ11

    property p_irq_level;
        ((irq_stat_r & irq_mask_r) != EV_RST) && !wr_stat && !wr_mask |=> irq_req_r;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt not raised");

    property p_blocked;
        nonvideo_blocked_o |->
            {4'h0, $past(back_porch_quiet_lines_r)} >= $past(vert_back_porch_len_i) &&
            {4'h0, $past(front_porch_quiet_lines_r)} >= $past(vert_front_porch_len_i) &&
            (!$past(burst_mode_i) || $past(nonvideo_burst_option_i));
    endproperty
    a_blocked: assert property (p_blocked) else $error("blocked without full window"); // RQ10

    sequence s_both_cover;
        window_gating_enable_i && host_if_sel_i == IF_SEL_RGB_SPI &&
        {4'h0, back_porch_quiet_lines_r} >= vert_back_porch_len_i &&
        {4'h0, front_porch_quiet_lines_r} >= vert_front_porch_len_i &&
        (!burst_mode_i || nonvideo_burst_option_i);
    endsequence

    property p_blocked_set;
        s_both_cover |=> nonvideo_blocked_o;
    endproperty
    a_blocked_set: assert property (p_blocked_set) else $error("traffic not stopped"); // RQ10

    property p_lane_reserved;
        reg_rd_i && reg_addr_i == LANE_ADDR |=> reg_rdata_o[15:2] == 14'h0000;
    endproperty
    a_lane_reserved: assert property (p_lane_reserved) else $error("reserved bits set"); // RQ12

endmodule

// ===== tb/video_timing_model.sv
// far side model: video timing source giving the porch position
// assumes the bench picks phase and line number right after a clock edge
module video_timing_model (
    input  wire logic [1:0] phase_i,
    input  wire logic [7:0] n_i,
    output logic            in_back_porch_o,
    output logic [7:0]      bp_lines_left_o,
    output logic            in_front_porch_o,
    output logic [7:0]      fp_line_idx_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // counts outside their porch are scrambled so the gate cannot lean on them
    assign in_back_porch_o  = (phase_i == 2'h1);
    assign in_front_porch_o = (phase_i == 2'h2);
    assign bp_lines_left_o  = in_back_porch_o ? n_i : ~n_i;
    assign fp_line_idx_o    = in_front_porch_o ? n_i : ~n_i;
endmodule

// ===== tb/bridge_irq_lane_window_regs_bench.sv
// bench for the interrupt pin, porch quiet window and lane registers
// assumes one 50 MHz clock and the strobe register port of the design
module bridge_irq_lane_window_regs_bench;
    import bridge_cfg_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, window_gating_enable = 1'b0, ifs = 1'b0;
    logic burst = 1'b0, nonvideo_burst_option = 1'b0, hold, blk, irq, oen, ibp, ifp;
    logic [7:0] addr = 8'h00, vert_back_porch_len = 8'h00, vert_front_porch_len = 8'h00, n = 8'h00, bpl, fpi;
    logic [15:0] wdat = 16'h0000, rdat;
    logic [1:0] ph = 2'h0, lsel;
    logic [3:0] len;
    int n_fail = 0, comparisons = 0;
    always #10 clk = ~clk;
    video_timing_model tm (.phase_i(ph), .n_i(n), .in_back_porch_o(ibp),
        .bp_lines_left_o(bpl), .in_front_porch_o(ifp), .fp_line_idx_o(fpi));
    bridge_irq_lane_window_regs DUT (.sys_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr),
        .reg_wdata_i(wdat), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat),
        .window_gating_enable_i(window_gating_enable), .host_if_sel_i(ifs), .vert_back_porch_len_i(vert_back_porch_len),
        .vert_front_porch_len_i(vert_front_porch_len), .in_back_porch_i(ibp), .bp_lines_left_i(bpl),
        .in_front_porch_i(ifp), .fp_line_idx_i(fpi), .burst_mode_i(burst),
        .nonvideo_burst_option_i(nonvideo_burst_option), .nonvideo_hold_o(hold), .nonvideo_blocked_o(blk),
        .lane_count_sel_o(lsel), .lane_enable_o(len), .irq_o(irq), .irq_oe_n_o(oen));
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask
    task reg_wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk); addr <= a; wdat <= d; wr <= 1'b1;
        @(posedge clk); wr <= 1'b0;
    endtask
    task reg_rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk); addr <= a; rd <= 1'b1;
        @(posedge clk); rd <= 1'b0;
        #1 chk("rdata", e, rdat);
    endtask
    // porch case: position, quiet fields, porch lengths, then expected hold and blocked
    task pc(input logic [1:0] p, input logic [7:0] nn, input logic [3:0] bq, input logic [3:0] fq,
            input logic [7:0] lb, input logic [7:0] lf, input logic eh, input logic eb);
        reg_wr(PORCH_ADDR, {8'hff, bq, fq});
        @(posedge clk); ph <= p; n <= nn; vert_back_porch_len <= lb; vert_front_porch_len <= lf;
        @(posedge clk); #1 chk("hold", 16'(eh), 16'(hold));
        chk("blocked", 16'(eb), 16'(blk));
    endtask
    task finish_test;
        if (n_fail == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_reset;
        #1 chk("irq", 16'h1, 16'(irq));
        chk("oe_n", 16'h0, 16'(oen));
        chk("lane_en", 16'h1, 16'(len));
        reg_rd(IRQ_PIN_ADDR, 16'h0);
        reg_rd(PORCH_ADDR, 16'h0);
        reg_rd(8'hdf, 16'h0);
    endtask
    task t_lane;
        for (int k = 0; k < 4; k++) begin
            reg_wr(LANE_ADDR, 16'hfffc | 16'(k));
            reg_rd(LANE_ADDR, 16'(k));
            chk("lane_sel", 16'(k), 16'(lsel));
            chk("lane_en", 16'((1 << (k + 1)) - 1), 16'(len));
        end
    endtask
    task t_irq_type;
        for (int v = 0; v < 8; v++) begin
            reg_wr(IRQ_PIN_ADDR, 16'hfff8 | 16'(v));
            reg_rd(IRQ_PIN_ADDR, 16'(v));
            chk("oe_n", 16'(v > 1), 16'(oen));
            chk("irq", 16'(v < 2 ? ~v & 1 : v >> 2), 16'(irq));
        end
    endtask
    task t_lock;
        reg_wr(IRQ_PIN_ADDR, 16'h0005);
        reg_wr(IRQ_MASK_ADDR, 16'h0004);
        reg_wr(IRQ_PIN_ADDR, 16'h0002);
        reg_rd(IRQ_PIN_ADDR, 16'h0005);
        reg_rd(IRQ_MASK_ADDR, 16'h0004);
        reg_rd(IRQ_STAT_ADDR, 16'h0004);
        chk("irq", 16'h1, 16'(irq));
        reg_wr(IRQ_STAT_ADDR, 16'h0004);
        repeat (3) @(posedge clk);
        #1 chk("oe_n", 16'h1, 16'(oen));
    endtask
    task t_porch;
        @(posedge clk); window_gating_enable <= 1'b1;
        pc(2'h2, 8'd1, 4'd0, 4'd2, 8'd10, 8'd5, 1'b1, 1'b0);
        pc(2'h2, 8'd2, 4'd0, 4'd2, 8'd10, 8'd5, 1'b0, 1'b0);
        pc(2'h2, 8'd2, 4'd0, 4'd9, 8'd10, 8'd3, 1'b1, 1'b0);
        pc(2'h2, 8'd3, 4'd0, 4'd9, 8'd10, 8'd3, 1'b0, 1'b0);
        pc(2'h1, 8'd3, 4'd3, 4'd0, 8'd10, 8'd5, 1'b1, 1'b0);
        pc(2'h1, 8'd4, 4'd3, 4'd0, 8'd10, 8'd5, 1'b0, 1'b0);
        pc(2'h1, 8'd4, 4'd9, 4'd0, 8'd4, 8'd5, 1'b1, 1'b0);
        pc(2'h0, 8'd0, 4'd15, 4'd15, 8'd4, 8'd5, 1'b0, 1'b1);
        @(posedge clk); burst <= 1'b1;
        pc(2'h0, 8'd0, 4'd15, 4'd15, 8'd4, 8'd5, 1'b0, 1'b0);
        @(posedge clk); nonvideo_burst_option <= 1'b1;
        pc(2'h0, 8'd0, 4'd15, 4'd15, 8'd4, 8'd5, 1'b0, 1'b1);
        @(posedge clk); window_gating_enable <= 1'b0;
        pc(2'h2, 8'd1, 4'd0, 4'd2, 8'd10, 8'd5, 1'b0, 1'b0);
        @(posedge clk); window_gating_enable <= 1'b1; ifs <= 1'b1;
        pc(2'h2, 8'd1, 4'd0, 4'd2, 8'd10, 8'd5, 1'b0, 1'b0);
        reg_rd(IRQ_STAT_ADDR, 16'h0003);
    endtask
    // a hang stops the run well past the roughly 130 cycles the tests need
    initial begin
        #200us;
        n_fail++;
        finish_test;
    end
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset;
        t_lane;
        t_irq_type;
        t_lock;
        t_porch;
        finish_test;
    end
endmodule
